/* File: core/tnsg_pkg.sv */
// Purpose: Shared constants and types for the tone and noise sound generator.
// Assumes: One reference clock; the host writes bytes over an 8-bit bus with chip and write enables.
// Notes: Destination codes follow the three-bit select field of a first byte.
package tnsg_pkg;
  // Destination select codes carried in bits 6 to 4 of a first byte.
  localparam logic [2:0] TNSG_SEL_TONE1_PERIOD = 3'h0;
  localparam logic [2:0] TNSG_SEL_TONE1_VOLUME = 3'h1;
  localparam logic [2:0] TNSG_SEL_TONE2_PERIOD = 3'h2;
  localparam logic [2:0] TNSG_SEL_TONE2_VOLUME = 3'h3;
  localparam logic [2:0] TNSG_SEL_TONE3_PERIOD = 3'h4;
  localparam logic [2:0] TNSG_SEL_TONE3_VOLUME = 3'h5;
  localparam logic [2:0] TNSG_SEL_NOISE_SETUP = 3'h6;
  localparam logic [2:0] TNSG_SEL_NOISE_VOLUME = 3'h7;
  // Byte field positions.
  localparam int TNSG_FIRST_FLAG_BIT = 7;
  localparam int TNSG_SEL_LSB = 4;
  localparam int TNSG_FEEDBACK_BIT = 2;
  // Reset values.
  localparam logic [3:0] TNSG_VOLUME_OFF = 4'hf;
  localparam logic [9:0] TNSG_PERIOD_RESET = 10'h000;
  localparam logic [2:0] TNSG_NOISE_SETUP_RESET = 3'h0;
  localparam logic [14:0] TNSG_LFSR_SEED = 15'h4000;
  // Timing: reference prescale and noise rate dividers, in reference clocks.
  localparam int TNSG_TONE_PRESCALE = 16;
  localparam int TNSG_NOISE_DIV0 = 512;
  localparam int TNSG_NOISE_DIV1 = 1024;
  localparam int TNSG_NOISE_DIV2 = 2048;
  localparam int TNSG_LOAD_CYCLES = 32;
  // Noise rate codes.
  localparam logic [1:0] TNSG_RATE_TONE3 = 2'h3;
  // Write sequencer states.
  typedef enum logic [2:0]
  {
    TNSG_IDLE = 3'b001,
    TNSG_LOAD = 3'b010,
    TNSG_DONE = 3'b100
  } tnsg_wstate_t;
endpackage : tnsg_pkg

/* File: core/tnsg_tone.sv */
// Purpose: One square-wave tone channel with a reloading half-period down-counter.
// Assumes: tick_i pulses once every sixteen reference clocks.
// Notes: A zero period toggles on every tick, the fastest possible tone.
module tnsg_tone
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic [9:0] period_i,
  output logic level_o,
  output logic borrow_o
);
  typedef struct packed
  {
    logic [9:0] count;
    logic level;
  } tnsg_tone_t;

  tnsg_tone_t st_q;
  tnsg_tone_t st_d;

  // Count down each tick; at one (or zero) toggle the output and reload.
  always_comb
  begin
    st_d = st_q;
    borrow_o = 1'b0;
    if (tick_i)
    begin
      if (st_q.count == 10'h000 || st_q.count == 10'h001)
      begin
        borrow_o = 1'b1;
        st_d.level = ~st_q.level;
        st_d.count = period_i;
      end
      else
      begin
        st_d.count = st_q.count - 10'h001;
      end
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
    end
    else if (ce_i)
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;
endmodule : tnsg_tone

/* File: core/tnsg_top.sv */
// Purpose: Three tone channels, one noise channel, per-channel attenuation and a summed output.
// Assumes: Chip enable, write enable and data arrive from outside and are synchronised here.
// Notes: Registers are write-only; output level is a digital sum, not an analog voltage.
// Functional notes
// - Each tone counter reloads its 10-bit half period and counts down every sixteen clocks.
// - Counter reaching one (or sitting at zero) toggles the tone output and reloads the period.
// - Tone output frequency is the clock over thirty-two times the period.
// - Period bit 9 is most significant, bit 0 least significant.
// - Volume bits weigh 2, 4, 8 and 16 dB from low to high; the code instead subtracts the volume code linearly from 15.
// - Weights add up to 30 dB; all four set silences the channel.
// - Noise uses an XOR-feedback shift register that cannot stick at zero.
// - Feedback select zero gives periodic noise, one gives white noise.
// - Any write to the noise setup register reloads the shift register with its seed.
// - Rate field picks clock over 512, 1024, 2048, or the tone 3 output.
// - Output sums the three attenuated tones and the attenuated noise.
// - Period updates take two bytes, volume and noise setup one, over eight lines.
// - Last selected destination is latched; data-only bytes update its upper six bits when it is a tone period.
// - Eight write-only registers; first byte carries a three-bit destination field.
// - Codes 0 to 5 alternate tone period and volume; 6 noise setup; 7 noise volume.
// - First byte: bit 7 set, select 6..4, data 3..0; second: bit 7 clear, data 5..0.
// - Noise setup byte: bit 2 feedback select, bits 1..0 rate, bit 3 unused.
// - Ready drops once chip enable has passed the synchroniser and returns after 32 clocks.
module tnsg_top
#(
  parameter int LOAD_CYCLES = tnsg_pkg::TNSG_LOAD_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_EN,
  input wire logic CHIP_EN_N,
  input wire logic WRITE_EN_N,
  input wire logic [7:0] DATA,
  output logic READY_O,
  output logic READY_OE_N,
  output logic [5:0] AUDIO
);
  typedef struct packed
  {
    logic [2:0] ce_sync;
    logic [2:0] we_sync;
    logic [7:0] data_s1;
    logic [7:0] data_s2;
    tnsg_pkg::tnsg_wstate_t wstate;
    logic [5:0] load_cnt;
    logic [7:0] byte_held;
    logic [2:0] dest;
    logic [2:0][9:0] period;
    logic [3:0][3:0] volume;
    logic [2:0] noise_setup;
    logic [14:0] lfsr;
    logic [10:0] prediv;
    logic tone3_prev;
    logic noise_level;
    logic [5:0] audio;
  } tnsg_state_t;

  tnsg_state_t st_q;
  tnsg_state_t st_d;

  logic [2:0] tone_level;
  logic tone_tick;
  logic [3:0] chan_on;
  logic [3:0][3:0] chan_amp;

  // Shared prescale of sixteen reference clocks for all tone counters.
  assign tone_tick = (st_q.prediv[3:0] == 4'hf);

  // One tone channel per generate entry.
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_tone
      tnsg_tone u_tone
      (
        .clk_i(CLOCK),
        .rst_i(RESET),
        .ce_i(CLOCK_EN),
        .tick_i(tone_tick),
        .period_i(st_q.period[g]),
        .level_o(tone_level[g]),
        .borrow_o()
      );
    end
  endgenerate

  // Channel amplitude: full scale 15 minus the volume code, zero when off.
  always_comb
  begin
    chan_on = {st_q.noise_level, tone_level};
    for (int i = 0; i < 4; i++)
    begin
      if (st_q.volume[i] == tnsg_pkg::TNSG_VOLUME_OFF || !chan_on[i])
      begin
        chan_amp[i] = 4'h0;
      end
      else
      begin
        chan_amp[i] = 4'hf - st_q.volume[i];
      end
    end
  end

  // Next-state logic for the host port, register file, noise source and mixer.
  always_comb
  begin
    logic ce_act;
    logic we_act;
    logic write_now;
    logic shift_now;
    logic fb_bit;
    logic [1:0] rate;
    logic [2:0] sel;
    st_d = st_q;
    ce_act = 1'b0;
    we_act = 1'b0;
    write_now = 1'b0;
    shift_now = 1'b0;
    fb_bit = 1'b0;
    rate = 2'h0;
    sel = 3'h0;
    // Three-stage synchronisers; an assertion counts once stages two and three agree.
    st_d.ce_sync = {st_q.ce_sync[1:0], ~CHIP_EN_N};
    st_d.we_sync = {st_q.we_sync[1:0], ~WRITE_EN_N};
    st_d.data_s1 = DATA;
    st_d.data_s2 = st_q.data_s1;
    ce_act = st_q.ce_sync[1] & st_q.ce_sync[2];
    we_act = st_q.we_sync[1] & st_q.we_sync[2];
    // Write sequencer: capture byte, hold ready low for the load time, then apply it.
    case (st_q.wstate)
      tnsg_pkg::TNSG_IDLE:
      begin
        // Idle is only re-entered after the strobe is seen released, so a level test is enough here.
        if (ce_act && we_act)
        begin
          st_d.byte_held = st_q.data_s2;
          st_d.load_cnt = 6'h00;
          st_d.wstate = tnsg_pkg::TNSG_LOAD;
        end
      end
      tnsg_pkg::TNSG_LOAD:
      begin
        st_d.load_cnt = st_q.load_cnt + 6'h01;
        if (st_q.load_cnt == 6'(LOAD_CYCLES - 2))
        begin
          write_now = 1'b1;
          st_d.wstate = tnsg_pkg::TNSG_DONE;
        end
      end
      tnsg_pkg::TNSG_DONE:
      begin
        // Wait for the strobe to be released so a long strobe writes only once.
        if (!(ce_act && we_act))
        begin
          st_d.wstate = tnsg_pkg::TNSG_IDLE;
        end
      end
      default:
      begin
        st_d.wstate = tnsg_pkg::TNSG_IDLE;
      end
    endcase
    // Register file update.
    sel = st_q.dest;
    if (write_now)
    begin
      if (st_q.byte_held[tnsg_pkg::TNSG_FIRST_FLAG_BIT])
      begin
        sel = st_q.byte_held[6:4];
        st_d.dest = sel;
        case (sel)
          tnsg_pkg::TNSG_SEL_TONE1_PERIOD, tnsg_pkg::TNSG_SEL_TONE2_PERIOD, tnsg_pkg::TNSG_SEL_TONE3_PERIOD:
          begin
            st_d.period[sel[2:1]][3:0] = st_q.byte_held[3:0];
          end
          tnsg_pkg::TNSG_SEL_NOISE_SETUP:
          begin
            st_d.noise_setup = st_q.byte_held[2:0];
            st_d.lfsr = tnsg_pkg::TNSG_LFSR_SEED;
          end
          default:
          begin
            st_d.volume[sel[2:1]] = st_q.byte_held[3:0];
          end
        endcase
      end
      else if (!sel[0] && sel != tnsg_pkg::TNSG_SEL_NOISE_SETUP)
      begin
        st_d.period[sel[2:1]][9:4] = st_q.byte_held[5:0];
      end
    end
    // Noise shift clock: fixed dividers or the rising edge of tone 3.
    st_d.prediv = st_q.prediv + 11'h001;
    st_d.tone3_prev = tone_level[2];
    rate = st_q.noise_setup[1:0];
    case (rate)
      2'h0: shift_now = (st_q.prediv[8:0] == 9'h1ff);
      2'h1: shift_now = (st_q.prediv[9:0] == 10'h3ff);
      2'h2: shift_now = (st_q.prediv == 11'h7ff);
      default: shift_now = tone_level[2] & ~st_q.tone3_prev;
    endcase
    if (shift_now && !(write_now && sel == tnsg_pkg::TNSG_SEL_NOISE_SETUP))
    begin
      if (st_q.noise_setup[tnsg_pkg::TNSG_FEEDBACK_BIT])
      begin
        fb_bit = st_q.lfsr[0] ^ st_q.lfsr[1];
      end
      else
      begin
        fb_bit = st_q.lfsr[0];
      end
      st_d.lfsr = {fb_bit, st_q.lfsr[14:1]};
      if (st_d.lfsr == 15'h0000)
      begin
        st_d.lfsr = tnsg_pkg::TNSG_LFSR_SEED;
      end
      st_d.noise_level = st_q.lfsr[0];
    end
    // Mixer: digital sum of four channel amplitudes.
    st_d.audio = 6'(chan_amp[0]) + 6'(chan_amp[1]) + 6'(chan_amp[2]) + 6'(chan_amp[3]);
  end

  // State register; the reset value makes every channel silent.
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      st_q <= '0;
      st_q.wstate <= tnsg_pkg::TNSG_IDLE;
      st_q.period <= {3{tnsg_pkg::TNSG_PERIOD_RESET}};
      st_q.volume <= {4{tnsg_pkg::TNSG_VOLUME_OFF}};
      st_q.noise_setup <= tnsg_pkg::TNSG_NOISE_SETUP_RESET;
      st_q.lfsr <= tnsg_pkg::TNSG_LFSR_SEED;
    end
    else if (CLOCK_EN)
    begin
      st_q <= st_d;
    end
  end

  // Ready is open collector: pulled low from synchronised chip enable until the load is done.
  always_comb
  begin
    READY_O = 1'b0;
    READY_OE_N = ~((st_q.ce_sync[1] & st_q.ce_sync[2]) && st_q.wstate != tnsg_pkg::TNSG_DONE);
  end

  assign AUDIO = st_q.audio;
endmodule : tnsg_top

/* File: test/tnsg_host.sv */
// Purpose: Host model that strobes bytes into the sound generator.
// Assumes: The ready wire idles high and goes low while a byte loads.
// Notes: Released data shows the inverse byte so stale values are never trusted.
module tnsg_host
(
  input wire logic clk,
  input wire logic ready,
  output logic ce_n,
  output logic we_n,
  output logic [7:0] data,
  output logic to
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    ce_n = 1'b1;
    we_n = 1'b1;
    data = 8'h00;
    to = 1'b0;
  end
  // Hold the strobe until ready rises after its drop; a lost ready raises the timeout flag.
  task automatic send(input logic [7:0] b);
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    @(posedge clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    data <= b;
    while (!(seen && ready) && n < 200)
    begin
      @(posedge clk);
      n++;
      seen = seen | !ready;
    end
    to = to | (n >= 200);
    ce_n <= 1'b1;
    we_n <= 1'b1;
    data <= ~b;
    repeat (36) @(posedge clk);
  endtask : send
endmodule : tnsg_host

/* File: test/tnsg_top_asserts.sv */
// Purpose: Port assertions for the sound generator top.
// Assumes: The clock enable is only dropped while no byte is loading.
// Notes: Ready low time is counted in a helper register.
module tnsg_top_asserts
#(
  parameter int LOAD_CYCLES = 32
)
(
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CLOCK_EN,
  input wire logic CHIP_EN_N,
  input wire logic WRITE_EN_N,
  input wire logic [7:0] DATA,
  input wire logic READY_O,
  input wire logic READY_OE_N,
  input wire logic [5:0] AUDIO
);
  logic [7:0] low_q;
  logic wrote_q;
  // Count ready low cycles and note the first completed write.
  always_ff @(posedge CLOCK)
  begin
    low_q <= READY_OE_N ? 8'h00 : low_q + 8'h01;
    wrote_q <= RESET ? 1'b0 : (wrote_q | $rose(READY_OE_N));
  end
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  property p_ready_wire;
    READY_O == 1'b0;
  endproperty
  a_ready_wire: assert property (p_ready_wire) else $error("ready data not low");
  property p_reset_quiet;
    $fell(RESET) |-> AUDIO == 6'h00 && READY_OE_N;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("not quiet after reset");
  property p_silent;
    !wrote_q |-> AUDIO == 6'h00;
  endproperty
  a_silent: assert property (p_silent) else $error("sound before any write");
  property p_ready_drop;
    $fell(CHIP_EN_N) && READY_OE_N |-> ##[1:4] !READY_OE_N;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready did not drop");
  property p_ready_cause;
    $fell(READY_OE_N) |-> !CHIP_EN_N && $past(!CHIP_EN_N);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready dropped without select");
  property p_load_len;
    $rose(READY_OE_N) |-> low_q >= LOAD_CYCLES - 1 && low_q <= LOAD_CYCLES + 1;
  endproperty
  a_load_len: assert property (p_load_len) else $error("load time wrong");
  property p_ready_hold;
    $rose(READY_OE_N) |-> READY_OE_N [*4];
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready not held");
  property p_audio_max;
    AUDIO <= 6'h3c;
  endproperty
  a_audio_max: assert property (p_audio_max) else $error("output sum too high");
endmodule : tnsg_top_asserts
bind tnsg_top tnsg_top_asserts #(.LOAD_CYCLES(LOAD_CYCLES)) u_chk (.CLOCK(CLOCK), .RESET(RESET),
  .CLOCK_EN(CLOCK_EN), .CHIP_EN_N(CHIP_EN_N), .WRITE_EN_N(WRITE_EN_N), .DATA(DATA),
  .READY_O(READY_O), .READY_OE_N(READY_OE_N), .AUDIO(AUDIO));

/* File: test/tnsg_top_tb.sv */
// Purpose: Self-checking bench for the tone and noise sound generator.
// Assumes: The host model drives the byte port and waits on ready.
// Notes: Timing is measured on the summed output, sampled on the falling edge.
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("mismatch at %0t got %h exp %h", $time, (a), (e)); end end
module tnsg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic ce_n;
  logic we_n;
  logic to;
  logic [7:0] data;
  logic ready_o;
  logic ready_oe_n;
  logic [5:0] audio;
  int n_fail = 0;
  int compares = 0;
  int c;
  always #50 clk = ~clk;
  // Open-collector ready with an external pull-up.
  wire ready_w = ready_oe_n ? 1'b1 : ready_o;
  tnsg_host host (.clk(clk), .ready(ready_w), .ce_n(ce_n), .we_n(we_n), .data(data), .to(to));
  tnsg_top dut (.CLOCK(clk), .RESET(rst), .CLOCK_EN(clk_en), .CHIP_EN_N(ce_n),
    .WRITE_EN_N(we_n), .DATA(data), .READY_O(ready_o), .READY_OE_N(ready_oe_n), .AUDIO(audio));
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // Bounded waits, so a stuck output shows as a count at the limit.
  task automatic wait_for(input logic [5:0] v, input int lim, output int n);
    n = 0;
    while (audio !== v && n < lim)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_for
  task automatic edge_len(output int n);
    logic [5:0] a;
    a = audio;
    n = 0;
    while (audio === a && n < 5000)
    begin
      @(negedge clk);
      n++;
    end
  endtask : edge_len
  task automatic t_reset;
    @(negedge clk);
    `CHK(audio, 6'h00)
    `CHK(ready_w, 1'b1)
    $display("test reset done");
  endtask : t_reset
  // Period in two bytes, then full volume, a new period, then volume steps to off.
  task automatic t_tone;
    host.send(8'h85);
    host.send(8'h00);
    host.send(8'h90);
    edge_len(c);
    edge_len(c);
    `CHK(c, 5 * tnsg_pkg::TNSG_TONE_PRESCALE)
    wait_for(6'h0f, 200, c);
    `CHK(audio, 6'h0f)
    // The last first byte named a volume, so the period must be selected again before a data byte.
    host.send(8'h85);
    host.send(8'h01);
    edge_len(c);
    edge_len(c);
    `CHK(c, 21 * tnsg_pkg::TNSG_TONE_PRESCALE)
    host.send(8'h95);
    wait_for(6'h0a, 800, c);
    `CHK(audio, 6'h0a)
    host.send(8'h9f);
    repeat (4) @(negedge clk);
    edge_len(c);
    `CHK(c, 5000)
    $display("test tone done");
  endtask : t_tone
  // Every feedback and rate code; the slowest rate is only written, to keep the run short.
  task automatic t_noise;
    int lim;
    host.send(8'hc1);
    host.send(8'hf0);
    for (int k = 0; k < 8; k++)
    begin
      host.send(8'he0 | 8'(k));
      lim = 16 * ((k % 4 == 3) ? 32 : (tnsg_pkg::TNSG_NOISE_DIV0 << (k % 4)));
      if (k % 4 != 2)
      begin
        wait_for(6'h00, lim, c);
        wait_for(6'h0f, lim, c);
        `CHK(c < lim, 1'b1)
      end
    end
    $display("test noise done");
  endtask : t_noise
  // Clock enable low must stretch a tone half period by exactly the frozen clocks; tone 2 and 3 codes are used.
  task automatic t_freeze;
    host.send(8'hff);
    host.send(8'h9f);
    host.send(8'ha3);
    host.send(8'h00);
    host.send(8'hb0);
    edge_len(c);
    fork
      edge_len(c);
      begin
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (200) @(posedge clk);
        clk_en <= 1'b1;
      end
    join
    `CHK(c, 3 * tnsg_pkg::TNSG_TONE_PRESCALE + 200)
    host.send(8'hbf);
    host.send(8'hd7);
    wait_for(6'h08, 100, c);
    `CHK(audio, 6'h08)
    $display("test freeze done");
  endtask : t_freeze
  // Watchdog covers the noise waits with a wide margin.
  initial
  begin
    repeat (90000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_tone();
    t_noise();
    t_freeze();
    `CHK(to, 1'b0)
    stop_test();
  end
endmodule : tnsg_top_tb
